// file: pkg/veil_pkg.sv
// constants of the video event interrupt lines block
package veil_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h06;
  localparam logic [7:0] IDX_LINE_ONE_CTRL = 8'h07;
  localparam logic [7:0] IDX_LINE_TWO_CTRL = 8'h08;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h0C;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h0D;
  // control register fields
  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_OVERFLOW_EN_BIT = 1;
  localparam int CTRL_UNDERFLOW_EN_BIT = 2;
  localparam int CTRL_LOCK_EN_BIT = 3;
  localparam int CTRL_INVERT_BIT = 4;
  localparam int CTRL_SELECT_LSB = 5;
  localparam int CTRL_SELECT_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // status register fields, all cleared by a read
  localparam int STAT_LINE_ONE_BIT = 0;
  localparam int STAT_LINE_TWO_BIT = 1;
  localparam int STAT_OVERFLOW_BIT = 2;
  localparam int STAT_UNDERFLOW_BIT = 3;
  localparam int STAT_LOCK_LOSS_BIT = 4;
  // event status and mask fields; status bits cleared by writing one, mask bits written directly
  localparam int EVT_LOCK_LOSS_BIT = 0;
  localparam int EVT_OVERFLOW_BIT = 1;
  localparam int EVT_UNDERFLOW_BIT = 2;
  localparam int EVT_LINE_ONE_BIT = 3;
  localparam int EVT_LINE_TWO_BIT = 4;
  localparam int EVT_W = 5;
  localparam logic [EVT_W-1:0] EVT_MASK_RESET = 5'h00;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  // number of monitored video timing events
  localparam int TIMING_EVENTS = 8;
endpackage

// file: rtl/veil_irq_lines.sv
// two open-drain interrupt request lines driven from video timing events and buffer flags
`timescale 1ns/1ns
`default_nettype none
module veil_irq_lines #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // video and buffer sources
  input wire logic [veil_pkg::TIMING_EVENTS-1:0] timingEvents,
  input wire logic display_pll_lock_input,
  input wire logic zoomOverflow,
  input wire logic zoomUnderflow,
  // open-drain request pins
  output logic interrupt_line_one_out,
  output logic interrupt_line_one_oe,
  output logic interrupt_line_two_out,
  output logic interrupt_line_two_oe,
  // summary interrupt
  output logic irqOut
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [veil_pkg::TIMING_EVENTS-1:0] eventMeta;
    logic [veil_pkg::TIMING_EVENTS-1:0] eventSync;
    logic lockMeta;
    logic lockSync;
    logic [1:0] eventPrev;
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic holdOne;
    logic holdTwo;
    logic lockLossFlag;
    logic overflowFlag;
    logic underflowFlag;
    logic lineOneSeen;
    logic lineTwoSeen;
    logic [veil_pkg::EVT_W-1:0] evtStatus;
    logic [veil_pkg::EVT_W-1:0] evtMask;
    logic dpWrite;
    logic [7:0] dpIndex;
    logic [31:0] rdata;
  } veil_state_t;

  veil_state_t state;
  veil_state_t next_state;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic selectEvent(
    input logic [7:0] ctrl,
    input logic [veil_pkg::TIMING_EVENTS-1:0] events
  );
    logic [veil_pkg::CTRL_SELECT_W-1:0] sel;
    sel = ctrl[veil_pkg::CTRL_SELECT_LSB +: veil_pkg::CTRL_SELECT_W];
    return events[sel] ^ ctrl[veil_pkg::CTRL_INVERT_BIT];
  endfunction

  function automatic logic enabledFlags(
    input logic [7:0] ctrl,
    input logic lockLoss,
    input logic overflow,
    input logic underflow
  );
    return (ctrl[veil_pkg::CTRL_LOCK_EN_BIT] & lockLoss)
      | (ctrl[veil_pkg::CTRL_OVERFLOW_EN_BIT] & overflow)
      | (ctrl[veil_pkg::CTRL_UNDERFLOW_EN_BIT] & underflow);
  endfunction

  function automatic logic lineLevel(
    input logic [7:0] ctrl,
    input logic event_,
    input logic hold,
    input logic flags
  );
    if (ctrl[veil_pkg::CTRL_LATCH_BIT])
    begin
      return hold | flags;
    end
    return event_ | flags;
  endfunction

  // ----------------------------------------
  // combinational view
  // ----------------------------------------
  logic eventOne;
  logic eventTwo;
  logic lineOne;
  logic lineTwo;
  logic addrTaken;
  logic [7:0] addrIndex;
  logic statusRead;
  logic dataWrite;
  logic [4:0] statusWord;

  always_comb
  begin
    eventOne = selectEvent(state.ctrlOne, state.eventSync);
    eventTwo = selectEvent(state.ctrlTwo, state.eventSync);
    lineOne = lineLevel(state.ctrlOne, eventOne, state.holdOne,
      enabledFlags(state.ctrlOne, state.lockLossFlag, state.overflowFlag,
        state.underflowFlag));
    lineTwo = lineLevel(state.ctrlTwo, eventTwo, state.holdTwo,
      enabledFlags(state.ctrlTwo, state.lockLossFlag, state.overflowFlag,
        state.underflowFlag));
    addrTaken = hsel & (htrans == veil_pkg::HTRANS_NONSEQ) & hready;
    addrIndex = 8'h00;
    if (haddr[1:0] == 2'h0 && (haddr >> 10) == '0)
    begin
      addrIndex = haddr[9:2];
    end
    statusRead = addrTaken & ~hwrite & (addrIndex == veil_pkg::IDX_STATUS);
    dataWrite = state.dpWrite & hready;
    statusWord = '0;
    statusWord[veil_pkg::STAT_LINE_ONE_BIT] = state.lineOneSeen;
    statusWord[veil_pkg::STAT_LINE_TWO_BIT] = state.lineTwoSeen;
    statusWord[veil_pkg::STAT_OVERFLOW_BIT] = state.overflowFlag;
    statusWord[veil_pkg::STAT_UNDERFLOW_BIT] = state.underflowFlag;
    statusWord[veil_pkg::STAT_LOCK_LOSS_BIT] = state.lockLossFlag;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic riseOne;
    logic riseTwo;
    logic [veil_pkg::EVT_W-1:0] evtSet;
    riseOne = 1'b0;
    riseTwo = 1'b0;
    evtSet = '0;
    next_state = state;
    // two-stage synchronisers
    next_state.eventMeta = timingEvents;
    next_state.eventSync = state.eventMeta;
    next_state.lockMeta = display_pll_lock_input;
    next_state.lockSync = state.lockMeta;
    // edge detection on the selected event
    next_state.eventPrev = {eventTwo, eventOne};
    riseOne = eventOne & ~state.eventPrev[0];
    riseTwo = eventTwo & ~state.eventPrev[1];

    // read-to-clear, then sets so that a coincident event wins
    if (statusRead)
    begin
      next_state.holdOne = 1'b0;
      next_state.holdTwo = 1'b0;
      next_state.lockLossFlag = 1'b0;
      next_state.overflowFlag = 1'b0;
      next_state.underflowFlag = 1'b0;
      next_state.lineOneSeen = 1'b0;
      next_state.lineTwoSeen = 1'b0;
    end
    if (state.ctrlOne[veil_pkg::CTRL_LATCH_BIT] && riseOne)
    begin
      next_state.holdOne = 1'b1;
    end
    if (state.ctrlTwo[veil_pkg::CTRL_LATCH_BIT] && riseTwo)
    begin
      next_state.holdTwo = 1'b1;
    end
    if (!state.lockSync)
    begin
      next_state.lockLossFlag = 1'b1;
    end
    if (zoomOverflow)
    begin
      next_state.overflowFlag = 1'b1;
    end
    if (zoomUnderflow)
    begin
      next_state.underflowFlag = 1'b1;
    end
    if (lineOne)
    begin
      next_state.lineOneSeen = 1'b1;
    end
    if (lineTwo)
    begin
      next_state.lineTwoSeen = 1'b1;
    end

    // bus data phase writes
    if (dataWrite)
    begin
      case (state.dpIndex)
        veil_pkg::IDX_LINE_ONE_CTRL: next_state.ctrlOne = hwdata[7:0];
        veil_pkg::IDX_LINE_TWO_CTRL: next_state.ctrlTwo = hwdata[7:0];
        veil_pkg::IDX_EVENT_STATUS:
          next_state.evtStatus = state.evtStatus & ~hwdata[veil_pkg::EVT_W-1:0];
        veil_pkg::IDX_EVENT_MASK: next_state.evtMask = hwdata[veil_pkg::EVT_W-1:0];
        default: next_state.evtMask = state.evtMask;
      endcase
    end

    // sticky events, set over clear
    evtSet[veil_pkg::EVT_LOCK_LOSS_BIT] = ~state.lockSync;
    evtSet[veil_pkg::EVT_OVERFLOW_BIT] = zoomOverflow;
    evtSet[veil_pkg::EVT_UNDERFLOW_BIT] = zoomUnderflow;
    evtSet[veil_pkg::EVT_LINE_ONE_BIT] = lineOne;
    evtSet[veil_pkg::EVT_LINE_TWO_BIT] = lineTwo;
    next_state.evtStatus = next_state.evtStatus | evtSet;

    // bus address phase
    if (hready)
    begin
      next_state.dpWrite = addrTaken & hwrite;
      next_state.dpIndex = addrIndex;
    end
    if (addrTaken && !hwrite)
    begin
      case (addrIndex)
        veil_pkg::IDX_STATUS: next_state.rdata = {27'h0000000, statusWord};
        veil_pkg::IDX_LINE_ONE_CTRL: next_state.rdata = {24'h000000, state.ctrlOne};
        veil_pkg::IDX_LINE_TWO_CTRL: next_state.rdata = {24'h000000, state.ctrlTwo};
        veil_pkg::IDX_EVENT_STATUS: next_state.rdata = {27'h0000000, state.evtStatus};
        veil_pkg::IDX_EVENT_MASK: next_state.rdata = {27'h0000000, state.evtMask};
        default: next_state.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state <= '0;
      state.lockMeta <= 1'b1;
      state.lockSync <= 1'b1;
      state.ctrlOne <= veil_pkg::CTRL_RESET;
      state.ctrlTwo <= veil_pkg::CTRL_RESET;
      state.evtMask <= veil_pkg::EVT_MASK_RESET;
    end
    else if (clkEn)
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = veil_pkg::HRESP_OKAY;
  assign hrdata = state.rdata;
  assign interrupt_line_one_out = 1'b0;
  assign interrupt_line_one_oe = lineOne;
  assign interrupt_line_two_out = 1'b0;
  assign interrupt_line_two_oe = lineTwo;
  assign irqOut = |(state.evtStatus & state.evtMask);

endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the video event interrupt lines
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] timingEvents = 8'h00;
  logic lockIn = 1'b1;
  logic zoomOverflow = 1'b0;
  logic zoomUnderflow = 1'b0;
  logic clkEn = 1'b1;
  logic hreadyout, hresp, oneOut, oneOe, twoOut, twoOe, irqOut, pinOneN, pinTwoN;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [11:0] a;
  wire hready = hreadyout;
  int badCount = 0;
  int checks = 0;
  int l;
  int i;
  veil_irq_lines u_dut (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timingEvents(timingEvents), .display_pll_lock_input(lockIn),
    .zoomOverflow(zoomOverflow), .zoomUnderflow(zoomUnderflow),
    .interrupt_line_one_out(oneOut), .interrupt_line_one_oe(oneOe),
    .interrupt_line_two_out(twoOut), .interrupt_line_two_oe(twoOe), .irqOut(irqOut));
  veil_host_model u_host (.oneOut(oneOut), .oneOe(oneOe), .twoOut(twoOut), .twoOe(twoOe),
    .pinOneN(pinOneN), .pinTwoN(pinTwoN));
  initial
    forever #4 clk_sys = ~clk_sys;
  // -----
  // tasks
  // -----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic busXfer(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= wr;
    htrans <= veil_pkg::HTRANS_NONSEQ;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_sys);
    zoomOverflow <= (b == 1);
    zoomUnderflow <= (b == 2);
    lockIn <= (b != 3);
    @(posedge clk_sys);
    zoomOverflow <= 1'b0;
    zoomUnderflow <= 1'b0;
    lockIn <= 1'b1;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    summarize();
  end
  // -----
  // tests
  // -----
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    busXfer(1'b0, 12'h01C, 0); check("ctrl one reset", rd, 32'h0);
    busXfer(1'b0, 12'h020, 0); check("ctrl two reset", rd, 32'h0);
    busXfer(1'b0, 12'h034, 0); check("mask reset", rd, 32'h0);
    busXfer(1'b1, 12'h400, 32'hFF);
    busXfer(1'b0, 12'h400, 0); check("unmapped", rd, 32'h0);
    busXfer(1'b1, 12'h020, 32'hFF);
    busXfer(1'b0, 12'h020, 0); check("ctrl two rw", rd, 32'hFF);
    busXfer(1'b1, 12'h020, 32'h00);
    for (l = 0; l < 2; l++)
    begin
      a = l ? 12'h020 : 12'h01C;
      for (i = 0; i < 8; i++)
      begin
        busXfer(1'b1, a, {24'h0, 3'(i), 5'h00});
        timingEvents <= 8'h01 << i;
        waitn(4); check("event low", l ? pinTwoN : pinOneN, 1'b0);
        @(posedge clk_sys);
        timingEvents <= 8'h00;
        waitn(4); check("event high", l ? pinTwoN : pinOneN, 1'b1);
      end
      busXfer(1'b1, a, 32'h10);
      waitn(4); check("inverted", l ? pinTwoN : pinOneN, 1'b0);
      busXfer(1'b1, a, 32'h01);
      busXfer(1'b0, 12'h018, 0);
      @(posedge clk_sys);
      timingEvents <= 8'h01;
      @(posedge clk_sys);
      timingEvents <= 8'h00;
      waitn(8); check("latched", l ? pinTwoN : pinOneN, 1'b0);
      // the other line, flow-through on event 0, also saw the pulse
      busXfer(1'b0, 12'h018, 0); check("line status", rd & 32'h3, 32'h3);
      waitn(1); check("latch cleared", l ? pinTwoN : pinOneN, 1'b1);
      for (i = 1; i < 4; i++)
      begin
        busXfer(1'b1, a, 32'h1 << i);
        busXfer(1'b0, 12'h018, 0);
        pulse(i);
        waitn(5); check("flag on", l ? pinTwoN : pinOneN, 1'b0);
        busXfer(1'b0, 12'h018, 0); check("status", rd, (32'h1 << (i + 1)) | (32'h1 << l));
        waitn(1); check("flag read", l ? pinTwoN : pinOneN, 1'b1);
        busXfer(1'b1, a, 32'h0);
        pulse(i);
        waitn(5); check("flag off", l ? pinTwoN : pinOneN, 1'b1);
      end
    end
    busXfer(1'b1, 12'h030, 32'h1F);
    busXfer(1'b1, 12'h034, 32'h02);
    pulse(1);
    waitn(3); check("irq set", irqOut, 1'b1);
    busXfer(1'b0, 12'h030, 0); check("event status", rd, 32'h02);
    busXfer(1'b1, 12'h034, 32'h0);
    waitn(1); check("irq masked", irqOut, 1'b0);
    busXfer(1'b1, 12'h034, 32'h02);
    waitn(1); check("irq unmasked", irqOut, 1'b1);
    busXfer(1'b1, 12'h030, 32'h02);
    waitn(1); check("irq cleared", irqOut, 1'b0);
    // an overflow while the clock enable is low must leave no trace
    @(posedge clk_sys);
    clkEn <= 1'b0;
    pulse(1);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    busXfer(1'b0, 12'h030, 0); check("frozen event status", rd, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

// file: tb/veil_host_model.sv
// host interrupt inputs with pull-ups on both request pins
`timescale 1ns/1ns
`default_nettype none
module veil_host_model (
  // request pins from the device
  input wire logic oneOut,
  input wire logic oneOe,
  input wire logic twoOut,
  input wire logic twoOe,
  // pin levels seen by the host
  output logic pinOneN,
  output logic pinTwoN
);
  // a released pin is pulled high
  assign pinOneN = oneOe ? oneOut : 1'b1;
  assign pinTwoN = twoOe ? twoOut : 1'b1;
endmodule
`default_nettype wire

// file: tb/veil_irq_monitor.sv
// port checker for the video event interrupt lines
`timescale 1ns/1ns
`default_nettype none
module veil_irq_monitor #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bus
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // sources and pins
  input wire logic [7:0] timingEvents,
  input wire logic display_pll_lock_input,
  input wire logic zoomOverflow,
  input wire logic interrupt_line_one_out,
  input wire logic interrupt_line_two_out,
  input wire logic interrupt_line_two_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ---------------------------------------
  // shadow of line two control, event sync
  // ---------------------------------------
  logic [7:0] ctrl;
  logic wrPend;
  logic [2:0] ev;
  logic take;
  logic rdStat;
  logic oe;
  assign oe = interrupt_line_two_oe;
  assign take = hsel && htrans == veil_pkg::HTRANS_NONSEQ && hready;
  assign rdStat = take && !hwrite && haddr == ADDR_W'(12'h018);
  always_ff @(posedge clk_sys)
  begin
    ev <= {ev[1:0], timingEvents[0]};
    if (reset)
    begin
      ctrl <= 8'h00;
      wrPend <= 1'b0;
    end
    else if (hready)
    begin
      wrPend <= take && hwrite && haddr == ADDR_W'(12'h020);
      if (wrPend)
        ctrl <= hwdata[7:0];
    end
  end
  // ----------
  // assertions
  // ----------
  a_bus_okay: assert property (hreadyout && hresp == veil_pkg::HRESP_OKAY)
    else $error("bus not ready");
  a_pins_open_drain: assert property (!interrupt_line_one_out && !interrupt_line_two_out)
    else $error("pin driven high");
  a_flow_event: assert property (ctrl == 8'h00 |-> oe == ev[1])
    else $error("flow line wrong");
  a_invert_event: assert property (ctrl == 8'h10 |-> oe == !ev[1])
    else $error("inverted line wrong");
  a_edge_sets_hold: assert property (ctrl == 8'h01 && ev[1] && !ev[2] |-> ##[0:1] oe)
    else $error("edge not held");
  a_hold_stays: assert property (ctrl == 8'h01 && oe && !rdStat ##1 ctrl == 8'h01 |-> oe)
    else $error("held line dropped");
  a_read_clears: assert property (ctrl == 8'h01 && rdStat && ev[1:0] == 2'b00 |=> !oe)
    else $error("read did not clear");
  a_overflow_line: assert property (ctrl == 8'h02 && zoomOverflow |=> oe)
    else $error("overflow missed");
  a_lock_loss_line: assert property (ctrl == 8'h08 && !display_pll_lock_input |-> ##[1:3] oe)
    else $error("lock loss missed");
  c_latched: cover property (ctrl == 8'h01 && oe);
  c_status_read: cover property (rdStat);
  c_lock_loss: cover property (ctrl == 8'h08 && !display_pll_lock_input);
endmodule
bind veil_irq_lines veil_irq_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .timingEvents(timingEvents), .display_pll_lock_input(display_pll_lock_input),
  .zoomOverflow(zoomOverflow), .interrupt_line_one_out(interrupt_line_one_out),
  .interrupt_line_two_out(interrupt_line_two_out), .interrupt_line_two_oe(interrupt_line_two_oe));
`default_nettype wire
